// file: src/tc_pkg.sv
// Constants, register indices and carrier types for the dual timer/counter.
// Assumes one 100 MHz clock that also serves as the oscillator input.
package tc_pkg;

  // ---------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_RUN_FLAGS = 8'h88;
  localparam logic [7:0] IDX_MODE_SEL  = 8'h89;
  localparam logic [7:0] IDX_T0_LOW    = 8'h8a;
  localparam logic [7:0] IDX_T1_LOW    = 8'h8b;
  localparam logic [7:0] IDX_T0_HIGH   = 8'h8c;
  localparam logic [7:0] IDX_T1_HIGH   = 8'h8d;
  localparam logic [7:0] IDX_CLK_CTL2  = 8'hbf;
  localparam logic [7:0] IDX_CLK_DIV   = 8'hc7;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int TF1_BIT  = 7;
  localparam int TR1_BIT  = 6;
  localparam int TF0_BIT  = 5;
  localparam int TR0_BIT  = 4;
  localparam int IE1_BIT  = 3;
  localparam int IT1_BIT  = 2;
  localparam int IE0_BIT  = 1;
  localparam int IT0_BIT  = 0;
  localparam int GATE1_BIT = 7;
  localparam int FUNC1_BIT = 6;
  localparam int GATE0_BIT = 3;
  localparam int FUNC0_BIT = 2;
  localparam int FAST_BIT  = 6;

  localparam logic [1:0] MODE_13BIT  = 2'b00;
  localparam logic [1:0] MODE_16BIT  = 2'b01;
  localparam logic [1:0] MODE_RELOAD = 2'b10;
  localparam logic [1:0] MODE_SPLIT  = 2'b11;

  // ---------------------------------------------------------------
  // Reset values and cycle counts
  // ---------------------------------------------------------------
  localparam logic [7:0]  RST_BYTE    = 8'h00;
  localparam logic [7:0]  RST_CLK_CTL2 = 8'h0a;
  localparam logic [2:0]  RST_DIV_CODE = 3'h0;
  localparam logic [3:0]  MC_NORMAL   = 4'hc;
  localparam logic [3:0]  MC_FAST     = 4'h6;
  localparam logic [2:0]  OPT_SETTLE  = 3'h5;
  localparam logic [1:0]  HRESP_OKAY  = 2'h0;
  localparam logic [31:0] RD_ZERO     = 32'h0000_0000;

  // ---------------------------------------------------------------
  // Carrier types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [2:0] sh;
    logic       q;
  } sync_state_t;

  typedef struct packed {
    logic [7:0] tl;
    logic [7:0] th;
    logic       ovf;
  } cnt_res_t;

  typedef struct packed {
    logic [7:0]  mode_sel;
    logic [7:0]  run_flags;
    logic [7:0]  t0_low;
    logic [7:0]  t0_high;
    logic [7:0]  t1_low;
    logic [7:0]  t1_high;
    logic [2:0]  div_code;
    logic [7:0]  clk_ctl2;
    logic [6:0]  pre_cnt;
    logic [3:0]  mc_cnt;
    logic [1:0]  cnt_prev;
    logic [1:0]  int_prev;
    logic [2:0]  opt_cnt;
    logic        ap_wr;
    logic [7:0]  ap_idx;
    logic        ap_ok;
    logic [31:0] hrdata;
    logic        hready;
  } top_state_t;

endpackage

// file: src/pin_sync.sv
// Three-stage synchroniser with agreement filter for one pin.
// Assumes the pin is asynchronous to sys_clk_i.
`timescale 1ns/1ps
module pin_sync (
  input  wire logic sys_clk_i,
  input  wire logic arst_n_i,
  input  wire logic pin_i,
  output logic      level_o
);

  tc_pkg::sync_state_t r_r;
  tc_pkg::sync_state_t r_nxt;

  // ---------------------------------------------------------------
  // Next state: output moves only when stages two and three agree
  // ---------------------------------------------------------------
  always_comb begin
    r_nxt    = r_r;
    r_nxt.sh = {r_r.sh[1:0], pin_i};
    if (r_r.sh[1] == r_r.sh[2]) begin
      r_nxt.q = r_r.sh[2];
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      // Start at the pulled-up idle level so no false low follows reset
      r_r <= '1;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign level_o = r_r.q;

endmodule

// file: src/dual_timer_top.sv
// Two timer/counters with clock prescaler and machine-cycle strobe, AHB-Lite slave.
// Assumes sys_clk_i is the oscillator input; acks come from interrupt logic on sys_clk_i.
//
// Functional notes
// - Timer function counts one per machine cycle, 12 or 6 prescaled clocks long.
// - Count pin is sampled once per machine cycle; samples detect events.
// - A sample of 1 followed by a sample of 0 counts once.
// - Gate bit 0: timer counts whenever its run bit is set.
// - Gate bit 1: counts only with run bit set and interrupt pin high.
// - Function bit 0 counts machine cycles, 1 counts count-pin falls.
// - Mode 00 is a 13-bit timer/counter for both timers.
// - Mode 01 is a full 16-bit timer/counter.
// - Mode 10 is an 8-bit low-byte counter with auto reload.
// - Reload overflow sets flag, copies high byte to low, high byte kept.
// - Timer 0 mode 11: low byte timer/counter, high byte timer only.
// - Split high byte uses timer one run bit and overflow flag.
// - Timer 1 in mode 11 stops and holds its value.
// - 13 and 16 bit modes flag overflow on all ones to zero.
// - Overflow flags set by hardware, cleared on vector ack or write.
// - Software drives run bits; timers start and stop with them.
// - Edge flags set on detected edge, cleared when serviced.
// - Type bit picks falling-edge or low-level interrupt trigger.
// - Divide code picks oscillator divide by two to the code.
// - Fast bit picks 6 or 12 clock cycle; reset value from option.
`timescale 1ns/1ps
module dual_timer_top (
  input  wire logic        sys_clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic [31:0]      hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  input  wire logic        count_pin_zero_i,
  input  wire logic        count_pin_one_i,
  input  wire logic        ext_interrupt_pin_zero_n_i,
  input  wire logic        ext_interrupt_pin_one_n_i,
  input  wire logic        fast_cycle_option_i,
  input  wire logic        t0_vector_ack_i,
  input  wire logic        t1_vector_ack_i,
  input  wire logic        x0_vector_ack_i,
  input  wire logic        x1_vector_ack_i,
  output logic             timer_zero_overflow_flag_o,
  output logic             timer_one_overflow_flag_o,
  output logic             ext_irq_zero_edge_flag_o,
  output logic             ext_irq_one_edge_flag_o
);

  tc_pkg::top_state_t r_r;
  tc_pkg::top_state_t r_nxt;

  logic cp0_q;
  logic cp1_q;
  logic ip0_q;
  logic ip1_q;
  logic opt_q;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  pin_sync u_cp0 (
    .sys_clk_i (sys_clk_i),
    .arst_n_i  (arst_n_i),
    .pin_i     (count_pin_zero_i),
    .level_o   (cp0_q)
  );
  pin_sync u_cp1 (
    .sys_clk_i (sys_clk_i),
    .arst_n_i  (arst_n_i),
    .pin_i     (count_pin_one_i),
    .level_o   (cp1_q)
  );
  pin_sync u_ip0 (
    .sys_clk_i (sys_clk_i),
    .arst_n_i  (arst_n_i),
    .pin_i     (ext_interrupt_pin_zero_n_i),
    .level_o   (ip0_q)
  );
  pin_sync u_ip1 (
    .sys_clk_i (sys_clk_i),
    .arst_n_i  (arst_n_i),
    .pin_i     (ext_interrupt_pin_one_n_i),
    .level_o   (ip1_q)
  );
  pin_sync u_opt (
    .sys_clk_i (sys_clk_i),
    .arst_n_i  (arst_n_i),
    .pin_i     (fast_cycle_option_i),
    .level_o   (opt_q)
  );

  // ---------------------------------------------------------------
  // One count step in modes 00, 01 and 10
  // ---------------------------------------------------------------
  function automatic tc_pkg::cnt_res_t step(input logic [1:0] m,
                                             input logic [7:0] tl,
                                             input logic [7:0] th);
    tc_pkg::cnt_res_t res;
    logic [16:0]      w;
    res = {tl, th, 1'b0};
    w   = 17'h0_0000;
    case (m)
      tc_pkg::MODE_13BIT: begin
        w       = {4'h0, th, tl[4:0]} + 17'h0_0001;
        res.tl  = {tl[7:5], w[4:0]};
        res.th  = w[12:5];
        res.ovf = w[13];
      end
      tc_pkg::MODE_16BIT: begin
        w       = {1'b0, th, tl} + 17'h0_0001;
        res.tl  = w[7:0];
        res.th  = w[15:8];
        res.ovf = w[16];
      end
      tc_pkg::MODE_RELOAD: begin
        if (tl == 8'hff) begin
          res.tl  = th;
          res.ovf = 1'b1;
        end else begin
          res.tl  = tl + 8'h01;
        end
      end
      default: begin
        res = {tl, th, 1'b0};
      end
    endcase
    return res;
  endfunction

  // ---------------------------------------------------------------
  // Read mux over the register file
  // ---------------------------------------------------------------
  function automatic logic [31:0] rd_mux(input tc_pkg::top_state_t s,
                                          input logic [7:0] idx);
    logic [31:0] d;
    d = tc_pkg::RD_ZERO;
    case (idx)
      tc_pkg::IDX_RUN_FLAGS: d = {24'h00_0000, s.run_flags};
      tc_pkg::IDX_MODE_SEL:  d = {24'h00_0000, s.mode_sel};
      tc_pkg::IDX_T0_LOW:    d = {24'h00_0000, s.t0_low};
      tc_pkg::IDX_T1_LOW:    d = {24'h00_0000, s.t1_low};
      tc_pkg::IDX_T0_HIGH:   d = {24'h00_0000, s.t0_high};
      tc_pkg::IDX_T1_HIGH:   d = {24'h00_0000, s.t1_high};
      tc_pkg::IDX_CLK_CTL2:  d = {24'h00_0000, s.clk_ctl2};
      tc_pkg::IDX_CLK_DIV:   d = {29'h0000_0000, s.div_code};
      default:               d = tc_pkg::RD_ZERO;
    endcase
    return d;
  endfunction

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    logic [7:0]       pre_top;
    logic [3:0]       mc_top;
    logic             sys_en;
    logic             mc_en;
    logic             ev0;
    logic             ev1;
    logic             inc0;
    logic             inc1;
    logic             set_tf0;
    logic             set_tf1;
    logic             fall0;
    logic             fall1;
    logic             take;
    logic [1:0]       m0;
    logic [1:0]       m1;
    logic [8:0]       b9;
    logic [7:0]       t;
    tc_pkg::cnt_res_t res;

    r_nxt   = r_r;
    pre_top = 8'h00;
    mc_top  = 4'h0;
    sys_en  = 1'b0;
    mc_en   = 1'b0;
    set_tf0 = 1'b0;
    set_tf1 = 1'b0;
    b9      = 9'h000;
    res     = '0;
    ev0     = 1'b0;
    ev1     = 1'b0;
    inc0    = 1'b0;
    inc1    = 1'b0;
    fall0   = 1'b0;
    fall1   = 1'b0;
    take    = 1'b0;
    t       = 8'h00;
    m0      = r_r.mode_sel[1:0];
    m1      = r_r.mode_sel[5:4];

    // Fast-cycle bit follows the option input until the strap has settled
    if (r_r.opt_cnt != tc_pkg::OPT_SETTLE) begin
      r_nxt.opt_cnt = r_r.opt_cnt + 3'h1;
      r_nxt.clk_ctl2[tc_pkg::FAST_BIT] = opt_q;
    end

    // Prescaler: one enable every two-to-the-code clocks
    pre_top = (8'h01 << r_r.div_code) - 8'h01;
    sys_en  = ({1'b0, r_r.pre_cnt} >= pre_top);
    r_nxt.pre_cnt = sys_en ? 7'h00 : r_r.pre_cnt + 7'h01;

    // Machine cycle: 6 or 12 prescaled clocks
    mc_top = r_r.clk_ctl2[tc_pkg::FAST_BIT] ? tc_pkg::MC_FAST - 4'h1
                                            : tc_pkg::MC_NORMAL - 4'h1;
    if (sys_en) begin
      mc_en        = (r_r.mc_cnt >= mc_top);
      r_nxt.mc_cnt = mc_en ? 4'h0 : r_r.mc_cnt + 4'h1;
    end

    // Count pins sampled once per machine cycle
    if (mc_en) begin
      r_nxt.cnt_prev = {cp1_q, cp0_q};
    end
    ev0 = mc_en & r_r.cnt_prev[0] & ~cp0_q;
    ev1 = mc_en & r_r.cnt_prev[1] & ~cp1_q;

    // Run, gate and source selection
    inc0 = r_r.run_flags[tc_pkg::TR0_BIT]
         & (~r_r.mode_sel[tc_pkg::GATE0_BIT] | ip0_q)
         & (r_r.mode_sel[tc_pkg::FUNC0_BIT] ? ev0 : mc_en);
    inc1 = r_r.run_flags[tc_pkg::TR1_BIT]
         & (~r_r.mode_sel[tc_pkg::GATE1_BIT] | ip1_q)
         & (r_r.mode_sel[tc_pkg::FUNC1_BIT] ? ev1 : mc_en);

    // Timer 0
    if (m0 == tc_pkg::MODE_SPLIT) begin
      if (inc0) begin
        b9            = {1'b0, r_r.t0_low} + 9'h001;
        r_nxt.t0_low  = b9[7:0];
        set_tf0       = b9[8];
      end
      if (r_r.run_flags[tc_pkg::TR1_BIT] & mc_en) begin
        b9            = {1'b0, r_r.t0_high} + 9'h001;
        r_nxt.t0_high = b9[7:0];
        set_tf1       = b9[8];
      end
    end else if (inc0) begin
      res           = step(m0, r_r.t0_low, r_r.t0_high);
      r_nxt.t0_low  = res.tl;
      r_nxt.t0_high = res.th;
      set_tf0       = res.ovf;
    end

    // Timer 1: holds in mode 11; its flag belongs to timer 0 in split mode
    if ((m1 != tc_pkg::MODE_SPLIT) && inc1) begin
      res           = step(m1, r_r.t1_low, r_r.t1_high);
      r_nxt.t1_low  = res.tl;
      r_nxt.t1_high = res.th;
      set_tf1       = set_tf1 | (res.ovf & (m0 != tc_pkg::MODE_SPLIT));
    end

    // External interrupt pins, edges on the filtered level
    r_nxt.int_prev = {ip1_q, ip0_q};
    fall0 = r_r.int_prev[0] & ~ip0_q;
    fall1 = r_r.int_prev[1] & ~ip1_q;

    // Software writes to data registers override counting
    if (r_r.ap_wr && r_r.ap_ok) begin
      case (r_r.ap_idx)
        tc_pkg::IDX_MODE_SEL: r_nxt.mode_sel = hwdata_i[7:0];
        tc_pkg::IDX_T0_LOW:   r_nxt.t0_low   = hwdata_i[7:0];
        tc_pkg::IDX_T1_LOW:   r_nxt.t1_low   = hwdata_i[7:0];
        tc_pkg::IDX_T0_HIGH:  r_nxt.t0_high  = hwdata_i[7:0];
        tc_pkg::IDX_T1_HIGH:  r_nxt.t1_high  = hwdata_i[7:0];
        tc_pkg::IDX_CLK_CTL2: r_nxt.clk_ctl2 = hwdata_i[7:0];
        tc_pkg::IDX_CLK_DIV:  r_nxt.div_code = hwdata_i[2:0];
        default: begin
        end
      endcase
    end

    // Control and flag register: write, then acks clear, then hardware sets win
    t = (r_r.ap_wr && r_r.ap_ok && (r_r.ap_idx == tc_pkg::IDX_RUN_FLAGS))
      ? hwdata_i[7:0] : r_r.run_flags;
    t[tc_pkg::TF0_BIT] = (t[tc_pkg::TF0_BIT] & ~t0_vector_ack_i) | set_tf0;
    t[tc_pkg::TF1_BIT] = (t[tc_pkg::TF1_BIT] & ~t1_vector_ack_i) | set_tf1;
    if (t[tc_pkg::IT0_BIT]) begin
      t[tc_pkg::IE0_BIT] = (t[tc_pkg::IE0_BIT] & ~x0_vector_ack_i) | fall0;
    end else begin
      t[tc_pkg::IE0_BIT] = ~ip0_q;
    end
    if (t[tc_pkg::IT1_BIT]) begin
      t[tc_pkg::IE1_BIT] = (t[tc_pkg::IE1_BIT] & ~x1_vector_ack_i) | fall1;
    end else begin
      t[tc_pkg::IE1_BIT] = ~ip1_q;
    end
    r_nxt.run_flags = t;

    // AHB-Lite address phase; zero wait states, read data from updated state
    take         = hsel_i & htrans_i[1] & hready_i;
    r_nxt.ap_wr  = take & hwrite_i;
    r_nxt.ap_idx = haddr_i[9:2];
    r_nxt.ap_ok  = (haddr_i[31:10] == 22'h00_0000);
    r_nxt.hready = 1'b1;
    if (take && !hwrite_i && r_nxt.ap_ok) begin
      r_nxt.hrdata = rd_mux(r_nxt, haddr_i[9:2]);
    end else begin
      r_nxt.hrdata = tc_pkg::RD_ZERO;
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      r_r           <= '0;
      r_r.mode_sel  <= tc_pkg::RST_BYTE;
      r_r.run_flags <= tc_pkg::RST_BYTE;
      r_r.t0_low    <= tc_pkg::RST_BYTE;
      r_r.t0_high   <= tc_pkg::RST_BYTE;
      r_r.t1_low    <= tc_pkg::RST_BYTE;
      r_r.t1_high   <= tc_pkg::RST_BYTE;
      r_r.div_code  <= tc_pkg::RST_DIV_CODE;
      r_r.clk_ctl2  <= tc_pkg::RST_CLK_CTL2;
    end else begin
      r_r <= r_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign hrdata_o    = r_r.hrdata;
  assign hreadyout_o = r_r.hready;
  assign hresp_o     = tc_pkg::HRESP_OKAY[0];
  assign timer_zero_overflow_flag_o = r_r.run_flags[tc_pkg::TF0_BIT];
  assign timer_one_overflow_flag_o  = r_r.run_flags[tc_pkg::TF1_BIT];
  assign ext_irq_zero_edge_flag_o   = r_r.run_flags[tc_pkg::IE0_BIT];
  assign ext_irq_one_edge_flag_o    = r_r.run_flags[tc_pkg::IE1_BIT];

endmodule

// file: dv/pin_model.sv
// Far-side model of the count pins and the active-low interrupt pins.
// Assumes the bench calls its tasks; pins idle high as pulled-up port pins.
`timescale 1ns/1ps
module pin_model (
  input  wire logic       sys_clk_i,
  output logic      [1:0] count_pin_o,
  output logic      [1:0] irq_pin_n_o
);
  initial begin
    count_pin_o = 2'b11;
    irq_pin_n_o = 2'b11;
  end

  // Each phase outlasts a machine cycle plus the input filter
  task automatic pulses(input int k, input int n);
    int half;
    for (int i = 0; i < n; i++) begin
      half = 30 + $urandom_range(15);
      @(posedge sys_clk_i);
      count_pin_o[k] <= 1'b0;
      repeat (half) @(posedge sys_clk_i);
      count_pin_o[k] <= 1'b1;
      repeat (half) @(posedge sys_clk_i);
    end
  endtask

  task automatic irq_level(input int k, input logic v);
    @(posedge sys_clk_i);
    irq_pin_n_o[k] <= v;
  endtask
endmodule

// file: dv/dual_timer_top_properties.sv
// Bus and flag properties of the dual timer/counter top.
// Assumes hreadyout_o is fed back as hready_i; bound to every top instance.
`timescale 1ns/1ps
module dual_timer_checker (
  input wire logic        sys_clk_i,
  input wire logic        arst_n_i,
  input wire logic        hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0]  htrans_i,
  input wire logic        hwrite_i,
  input wire logic [31:0] hwdata_i,
  input wire logic        hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic        hreadyout_o,
  input wire logic        hresp_o,
  input wire logic        ext_interrupt_pin_zero_n_i,
  input wire logic        ext_interrupt_pin_one_n_i,
  input wire logic        t0_vector_ack_i,
  input wire logic        t1_vector_ack_i,
  input wire logic        timer_zero_overflow_flag_o,
  input wire logic        timer_one_overflow_flag_o,
  input wire logic        ext_irq_zero_edge_flag_o,
  input wire logic        ext_irq_one_edge_flag_o
);
  logic       take;
  logic       rd_r;
  logic       wr_r;
  logic       rf_r;
  logic [1:0] run_r;
  logic [7:0] age_r;

  function automatic logic [3:0] sat(input logic [3:0] a);
    return (a == 4'hf) ? a : a + 4'h1;
  endfunction

  assign take = hsel_i && htrans_i[1] && hready_i;

  // Age counts cycles since each interrupt pin was last low
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rd_r  <= 1'b0;
      wr_r  <= 1'b0;
      rf_r  <= 1'b0;
      run_r <= 2'b00;
      age_r <= 8'h00;
    end else begin
      rd_r <= take && !hwrite_i;
      wr_r <= take && hwrite_i;
      rf_r <= haddr_i == {22'h0, tc_pkg::IDX_RUN_FLAGS, 2'b00};
      if (wr_r && rf_r) begin
        run_r <= {hwdata_i[tc_pkg::TR1_BIT], hwdata_i[tc_pkg::TR0_BIT]};
      end
      age_r[3:0] <= ext_interrupt_pin_zero_n_i ? sat(age_r[3:0]) : 4'h0;
      age_r[7:4] <= ext_interrupt_pin_one_n_i ? sat(age_r[7:4]) : 4'h0;
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);

  sequence ack_idle_s(logic ack, logic run);
    ack && !run;
  endsequence

  resp_okay_a: assert property (hresp_o == 1'b0)
    else $error("bus response not okay");
  ready_up_a: assert property ($past(arst_n_i) |-> hreadyout_o)
    else $error("bus stalled");
  upper_zero_a: assert property (hrdata_o[31:8] == 24'h00_0000)
    else $error("read data upper bits set");
  rd_quiet_a: assert property (!rd_r |-> hrdata_o == 32'h0000_0000)
    else $error("read data outside read phase");
  edge_zero_a: assert property (
    $rose(ext_irq_zero_edge_flag_o) |-> age_r[3:0] < 4'h8)
    else $error("pin zero flag without low pin");
  edge_one_a: assert property (
    $rose(ext_irq_one_edge_flag_o) |-> age_r[7:4] < 4'h8)
    else $error("pin one flag without low pin");
  ack_zero_a: assert property (ack_idle_s(t0_vector_ack_i, run_r[0]) |=>
    !timer_zero_overflow_flag_o) else $error("timer zero flag kept after ack");
  ack_one_a: assert property (ack_idle_s(t1_vector_ack_i, run_r[1]) |=>
    !timer_one_overflow_flag_o) else $error("timer one flag kept after ack");
  flag_hold_a: assert property (
    timer_zero_overflow_flag_o && !t0_vector_ack_i && !wr_r |=> timer_zero_overflow_flag_o)
    else $error("timer zero flag lost");
endmodule

bind dual_timer_top dual_timer_checker chk_u (
  .sys_clk_i, .arst_n_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hwdata_i, .hready_i,
  .hrdata_o, .hreadyout_o, .hresp_o, .ext_interrupt_pin_zero_n_i, .ext_interrupt_pin_one_n_i,
  .t0_vector_ack_i, .t1_vector_ack_i, .timer_zero_overflow_flag_o, .timer_one_overflow_flag_o,
  .ext_irq_zero_edge_flag_o, .ext_irq_one_edge_flag_o
);

// file: dv/tb_dual_timer_counter_with_clock_select.sv
// Self-checking bench of the dual timer/counter over its AHB-Lite port.
// Assumes the pin model drives the pins and the properties file is compiled.
`timescale 1ns/1ps
module tb_dual_timer_counter_with_clock_select;
  localparam logic [7:0] RF = tc_pkg::IDX_RUN_FLAGS;
  localparam logic [7:0] MS = tc_pkg::IDX_MODE_SEL;
  logic [7:0]  lo_i [2] = '{tc_pkg::IDX_T0_LOW, tc_pkg::IDX_T1_LOW};
  logic [7:0]  hi_i [2] = '{tc_pkg::IDX_T0_HIGH, tc_pkg::IDX_T1_HIGH};
  int          sc_mode [5] = '{0, 1, 2, 1, 1};
  int          sc_gate [5] = '{0, 0, 0, 1, 1};
  int          sc_low  [5] = '{0, 1, 0, 1, 0};
  logic        sys_clk_i = 1'b0;
  logic        arst_n_i = 1'b0;
  logic        hsel_i = 1'b0;
  logic [31:0] haddr_i = 32'h0000_0000;
  logic [1:0]  htrans_i = 2'b00;
  logic        hwrite_i = 1'b0;
  logic [31:0] hwdata_i = 32'h0000_0000;
  logic [31:0] hrdata_o;
  logic        hreadyout_o;
  logic        strap = 1'b0;
  logic [3:0]  acks = 4'h0;
  logic [3:0]  flg;
  logic [1:0]  cnt;
  logic [1:0]  irqn;
  logic [31:0] d;
  int          n_mismatch = 0;
  int          checks = 0;
  int          m_lo, m_hi, m_ovf, n, r1, r2;

  always #5 sys_clk_i = ~sys_clk_i;

  pin_model pins (.sys_clk_i, .count_pin_o(cnt), .irq_pin_n_o(irqn));

  dual_timer_top dut (
    .sys_clk_i, .arst_n_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i(3'b010),
    .hwdata_i, .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o, .hresp_o(),
    .count_pin_zero_i(cnt[0]), .count_pin_one_i(cnt[1]), .fast_cycle_option_i(strap),
    .ext_interrupt_pin_zero_n_i(irqn[0]), .ext_interrupt_pin_one_n_i(irqn[1]),
    .t0_vector_ack_i(acks[0]), .t1_vector_ack_i(acks[1]), .x0_vector_ack_i(acks[2]),
    .x1_vector_ack_i(acks[3]), .timer_zero_overflow_flag_o(flg[0]),
    .timer_one_overflow_flag_o(flg[1]), .ext_irq_zero_edge_flag_o(flg[2]),
    .ext_irq_one_edge_flag_o(flg[3])
  );

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One single word transfer; waits for ready in both phases
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] wd,
                     output logic [31:0] rd);
    @(posedge sys_clk_i);
    hsel_i   <= 1'b1;
    htrans_i <= 2'b10;
    haddr_i  <= {22'h0, idx, 2'b00};
    hwrite_i <= w;
    do @(posedge sys_clk_i); while (hreadyout_o !== 1'b1);
    hsel_i   <= 1'b0;
    htrans_i <= 2'b00;
    hwdata_i <= {24'h00_0000, wd};
    do @(posedge sys_clk_i); while (hreadyout_o !== 1'b1);
    rd = hrdata_o;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    logic [31:0] x;
    bus(1'b1, idx, v, x);
  endtask

  task automatic rd_chk(input string what, input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, idx, 8'h00, x);
    chk(what, x, exp);
  endtask

  task automatic ack(input int k);
    @(posedge sys_clk_i);
    acks[k] <= 1'b1;
    @(posedge sys_clk_i);
    acks[k] <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
  endtask

  // Reference count step for modes 00, 01 and 10
  task automatic m_step(input int mode);
    int v;
    if (mode == 2) begin
      m_lo++;
      if (m_lo == 256) begin
        m_lo = m_hi;
        m_ovf = 1;
      end
    end else begin
      v = mode ? m_hi * 256 + m_lo + 1 : m_hi * 32 + m_lo % 32 + 1;
      if (v == (mode ? 65536 : 8192)) begin
        v = 0;
        m_ovf = 1;
      end
      m_hi = mode ? v / 256 : v / 32;
      m_lo = mode ? v % 256 : m_lo / 32 * 32 + v % 32;
    end
  endtask

  // Cuts a hang short; the full run needs about 40000 cycles
  initial begin
    repeat (90000) @(posedge sys_clk_i);
    n_mismatch++;
    conclude();
  end

  initial begin
    void'($urandom(94739));
    strap <= 1'($urandom_range(1));
    repeat (20) @(posedge sys_clk_i);
    arst_n_i <= 1'b1;
    foreach (lo_i[k]) rd_chk("count low reset", lo_i[k], 32'h0000_0000);
    foreach (hi_i[k]) rd_chk("count high reset", hi_i[k], 32'h0000_0000);
    rd_chk("run flags reset", RF, 32'h0000_0000);
    rd_chk("mode reset", MS, 32'h0000_0000);
    rd_chk("divider reset", tc_pkg::IDX_CLK_DIV, 32'h0000_0000);
    rd_chk("clock two reset", tc_pkg::IDX_CLK_CTL2, {25'h0, strap, 6'h0a});
    wr(8'h90, 8'($urandom_range(255)));
    rd_chk("unmapped", 8'h90, 32'h0000_0000);
    wr(MS, 8'h01);
    for (int f = 0; f < 2; f++) begin
      for (int c = 0; c < 8; c++) begin
        wr(tc_pkg::IDX_CLK_CTL2, {1'b0, f[0], 6'h0a});
        wr(tc_pkg::IDX_CLK_DIV, c[7:0]);
        wr(lo_i[0], 8'h00);
        wr(RF, 8'h10);
        repeat (8 * ((f ? 6 : 12) << c)) @(posedge sys_clk_i);
        wr(RF, 8'h00);
        bus(1'b0, lo_i[0], 8'h00, d);
        chk("ticks", 32'(d inside {8, 9}), 32'h1);
      end
    end
    wr(tc_pkg::IDX_CLK_CTL2, 8'h0a);
    wr(tc_pkg::IDX_CLK_DIV, 8'h00);
    for (int t = 0; t < 2; t++) begin
      for (int s = 0; s < 5; s++) begin
        n = 1 + $urandom_range(3);
        m_hi = sc_mode[s] == 2 ? $urandom_range(255) : 255;
        m_lo = sc_mode[s] == 0 ? 32 * $urandom_range(7) + 29 : 252 + sc_mode[s];
        m_ovf = 0;
        wr(MS, 8'((4 + 8 * sc_gate[s] + sc_mode[s]) << (4 * t)));
        wr(lo_i[t], 8'(m_lo));
        wr(hi_i[t], 8'(m_hi));
        pins.irq_level(t, sc_low[s] == 0);
        wr(RF, 8'(t ? 'h40 : 'h10));
        pins.pulses(t, n);
        repeat (40) @(posedge sys_clk_i);
        for (int i = 0; i < n; i++) begin
          if (!(sc_gate[s] && sc_low[s])) m_step(sc_mode[s]);
        end
        chk("overflow flag", flg[t], 32'(m_ovf));
        wr(RF, 8'(m_ovf << (t ? 7 : 5)));
        rd_chk("count low", lo_i[t], 32'(m_lo));
        rd_chk("count high", hi_i[t], 32'(m_hi));
        ack(t);
        chk("flag after ack", flg[t], 32'h0);
        pins.irq_level(t, 1'b1);
      end
    end
    r1 = $urandom_range(255);
    r2 = $urandom_range(255);
    wr(MS, 8'h37);
    wr(lo_i[0], 8'hff);
    wr(hi_i[0], 8'hff);
    wr(lo_i[1], 8'(r1));
    wr(hi_i[1], 8'(r2));
    wr(RF, 8'h50);
    repeat (30) @(posedge sys_clk_i);
    chk("split high overflow", flg[1], 32'h1);
    chk("split low overflow", flg[0], 32'h0);
    rd_chk("split low count", lo_i[0], 32'h0000_00ff);
    rd_chk("held low", lo_i[1], 32'(r1));
    rd_chk("held high", hi_i[1], 32'(r2));
    wr(RF, 8'h00);
    repeat (2) @(posedge sys_clk_i);
    chk("flag cleared by write", flg[1], 32'h0);
    for (int x = 0; x < 2; x++) begin
      wr(RF, 8'(1 << (2 * x)));
      pins.irq_level(x, 1'b0);
      repeat (20) @(posedge sys_clk_i);
      pins.irq_level(x, 1'b1);
      repeat (20) @(posedge sys_clk_i);
      chk("edge flag held", flg[2 + x], 32'h1);
      ack(2 + x);
      chk("edge flag serviced", flg[2 + x], 32'h0);
      wr(RF, 8'h00);
      pins.irq_level(x, 1'b0);
      repeat (20) @(posedge sys_clk_i);
      chk("level flag low", flg[2 + x], 32'h1);
      pins.irq_level(x, 1'b1);
      repeat (20) @(posedge sys_clk_i);
      chk("level flag high", flg[2 + x], 32'h0);
    end
    conclude();
  end
endmodule
